// [core/adcc_ctrl.sv]
// converter control: mode, channel, result and interrupt registers
// assumes a strobe register port with read data one cycle after the strobe
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int unsigned STEP_CYCLES   = STEP_BASE
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  // analog front end
  output logic      [CHAN_W-1:0] chanSel,
  output logic                   compPower,
  output logic                   sampleHold,
  output logic      [RES_W-1:0]  dacCode,
  input  wire logic              compHigh,
  // interrupts
  output logic                   convDoneIrq,
  output logic                   irqOut
);
  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [CHAN_W-1:0] chan;
    logic [RES_W-1:0]  result;
    logic              stat;
    logic              mask;
    logic [DATA_W-1:0] rdata;
    logic              irqPulse;
  } adcc_regs_t;

  adcc_regs_t st_q;
  adcc_regs_t st_d;
  logic       wrMode;
  logic       wrChan;
  logic       doneTake;

  adcc_conv_if conv ();

  adcc_sar_seq #(
    .SAMPLE_CYCLES (SAMPLE_CYCLES),
    .STEP_CYCLES   (STEP_CYCLES)
  ) u_sar (
    .core_clk (core_clk),
    .rstn     (rstn),
    .conv     (conv.sar)
  );

  // ********************************
  // decode
  // ********************************
  assign wrMode   = regWr && (regAddr == OFS_MODE);
  assign wrChan   = regWr && (regAddr == OFS_CHAN);
  // a colliding mode or channel write wins over the completing result
  assign doneTake = conv.done && !(wrMode || wrChan);

  // ********************************
  // register file
  // ********************************
  always_comb begin
    st_d          = st_q;
    st_d.rdata    = '0;
    st_d.irqPulse = 1'b0;
    if (regRd) begin
      case (regAddr)
        OFS_MODE:   st_d.rdata[MODE_W-1:0]  = st_q.mode;
        OFS_CHAN:   st_d.rdata[CHAN_W-1:0]  = st_q.chan;
        // read samples the stored value before this edge updates it
        OFS_RESULT: st_d.rdata[RES_W-1:0]   = st_q.result;
        OFS_RESHI:  st_d.rdata[RESHI_W-1:0] = st_q.result[RES_W-1:RESHI_LSB];
        OFS_STAT:   st_d.rdata[STAT_DONE_BIT] = st_q.stat;
        OFS_MASK:   st_d.rdata[STAT_DONE_BIT] = st_q.mask;
        default:    st_d.rdata = '0;
      endcase
    end
    if (wrMode) begin
      st_d.mode = regWdata[MODE_W-1:0] & MODE_MASK;
    end
    // channel write leaves the done flag alone
    if (wrChan) begin
      st_d.chan = regWdata[CHAN_W-1:0];
    end
    if (regWr && (regAddr == OFS_MASK)) begin
      st_d.mask = regWdata[STAT_DONE_BIT];
    end
    if (regWr && (regAddr == OFS_STAT) && regWdata[STAT_DONE_BIT]) begin
      st_d.stat = 1'b0;
    end
    // set after clear so a same-cycle completion is not lost
    if (doneTake) begin
      st_d.result   = conv.result;
      st_d.stat     = 1'b1;
      st_d.irqPulse = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{mode: MODE_RESET, chan: CHAN_RESET, result: RES_RESET, stat: 1'b0,
                mask: 1'b0, rdata: '0, irqPulse: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ********************************
  // sequencer steering and outputs
  // ********************************
  assign conv.enable   = st_q.mode[MODE_RUN_BIT];
  assign conv.abort    = wrMode || wrChan;
  assign conv.timeSel  = st_q.mode[MODE_FR_LSB +: FR_W];
  assign conv.compHigh = compHigh;

  // power bit alone keeps only the comparator alive, no sampling
  assign compPower   = st_q.mode[MODE_PWR_BIT];
  assign sampleHold  = conv.sampling;
  assign dacCode     = conv.dacCode;
  assign chanSel     = st_q.chan;
  assign regRdata    = st_q.rdata;
  assign convDoneIrq = st_q.irqPulse;
  assign irqOut      = st_q.stat && st_q.mask;

  // ********************************
  // checks
  // ********************************
  a_read_old_value: assert property (@(posedge core_clk) disable iff (!rstn)
    regRd && (regAddr == OFS_RESULT) && conv.done
      |=> (regRdata[RES_W-1:0] == $past(st_q.result)) && (st_q.result == $past(conv.result)))
    else $error("colliding read did not see the old result");

  a_write_discard: assert property (@(posedge core_clk) disable iff (!rstn)
    conv.done && (wrMode || wrChan) |=> $stable(st_q.result) && !convDoneIrq)
    else $error("colliding write did not discard the update");

  a_wait_state: assert property (@(posedge core_clk) disable iff (!rstn)
    (!st_q.mode[MODE_RUN_BIT] && st_q.mode[MODE_PWR_BIT]) [*2] |-> compPower && !conv.busy)
    else $error("waiting state is converting");

  a_stop_at_once: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(st_q.mode[MODE_RUN_BIT]) |=> !conv.busy && !sampleHold)
    else $error("run clear did not stop conversion");

  a_flag_kept: assert property (@(posedge core_clk) disable iff (!rstn)
    st_q.stat && wrChan && !(regWr && (regAddr == OFS_STAT)) |=> st_q.stat)
    else $error("channel write cleared the done flag");

  a_done_sets: assert property (@(posedge core_clk) disable iff (!rstn)
    doneTake |=> st_q.stat && convDoneIrq ##1 !convDoneIrq)
    else $error("completion did not set flag with one pulse");

  a_flag_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
    st_q.stat && !regWr |=> st_q.stat)
    else $error("done flag dropped without a clear");

  a_high_view: assert property (@(posedge core_clk) disable iff (!rstn)
    regRd && (regAddr == OFS_RESHI)
      |=> regRdata == {{(DATA_W-RESHI_W){1'b0}}, $past(st_q.result[RES_W-1:RESHI_LSB])})
    else $error("high byte view wrong");
endmodule

// [core/adcc_pkg.sv]
// constants, register map and state types of the converter control block
// assumes one core clock and a plain strobe register port
// What this block does
// - result read colliding with result update returns the old value, then stores
// - mode or channel write colliding with update wins; update and interrupt dropped
// - run off, power on: comparator powered, no conversion running
// - channel register rewrite never clears the done flag
// - old-channel result may land and set the flag just before rewrite
// - after each completion the next conversion starts at once while run set
// - mode or channel write aborts conversion, restarts it if run set
// - clearing run stops conversion at once, result undefined
// - two channel bits pick one of four inputs; 10-bit result, 8-bit high view
package adcc_pkg;
  // ********************************
  // register map
  // ********************************
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;
  localparam logic [2:0] OFS_MODE   = 3'h0;
  localparam logic [2:0] OFS_CHAN   = 3'h1;
  localparam logic [2:0] OFS_RESULT = 3'h2;
  localparam logic [2:0] OFS_RESHI  = 3'h3;
  localparam logic [2:0] OFS_STAT   = 3'h4;
  localparam logic [2:0] OFS_MASK   = 3'h5;

  // ********************************
  // fields and reset values
  // ********************************
  localparam int unsigned MODE_W       = 8;
  localparam int unsigned MODE_RUN_BIT = 7;
  localparam int unsigned MODE_PWR_BIT = 0;
  localparam int unsigned MODE_FR_LSB  = 3;
  localparam int unsigned FR_W         = 3;
  localparam logic [7:0]  MODE_MASK    = 8'hB9;
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam int unsigned CHAN_W       = 2;
  localparam logic [1:0]  CHAN_RESET   = 2'h0;
  localparam int unsigned RES_W        = 10;
  localparam int unsigned RESHI_W      = 8;
  localparam int unsigned RESHI_LSB    = 2;
  localparam logic [9:0]  RES_RESET    = 10'h000;
  localparam int unsigned STAT_DONE_BIT = 0;

  // ********************************
  // sequencer timing
  // ********************************
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned BIT_IDX_W   = 4;
  localparam int unsigned SAMPLE_CYC  = 8;
  localparam int unsigned STEP_BASE   = 4;

  typedef enum logic [1:0] {
    ADCC_IDLE    = 2'b00,
    ADCC_SAMPLE  = 2'b01,
    ADCC_CONVERT = 2'b11
  } adcc_state_t;
endpackage

// [core/adcc_conv_if.sv]
// link between the register side and the approximation sequencer
// assumes both ends run on core_clk
`timescale 1ns/1ns
interface adcc_conv_if;
  import adcc_pkg::*;
  logic                 enable;
  logic                 abort;
  logic [FR_W-1:0]      timeSel;
  logic                 compHigh;
  logic                 busy;
  logic                 sampling;
  logic                 done;
  logic [RES_W-1:0]     result;
  logic [RES_W-1:0]     dacCode;

  modport ctrl (output enable, abort, timeSel, compHigh,
                input  busy, sampling, done, result, dacCode);
  modport sar  (input  enable, abort, timeSel, compHigh,
                output busy, sampling, done, result, dacCode);
endinterface

// [core/adcc_sar_seq.sv]
// successive-approximation sequencer: sample phase then one trial per bit
// assumes the comparator answer is settled by the end of each step
`timescale 1ns/1ns
module adcc_sar_seq
  import adcc_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int unsigned STEP_CYCLES   = STEP_BASE
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // control side
  adcc_conv_if.sar  conv
);
  typedef struct packed {
    adcc_state_t          state;
    logic [CNT_W-1:0]     cnt;
    logic [BIT_IDX_W-1:0] bitIdx;
    logic [RES_W-1:0]     code;
    logic [RES_W-1:0]     result;
    logic                 done;
  } adcc_sar_t;

  adcc_sar_t st_q;
  adcc_sar_t st_d;
  logic [CNT_W-1:0] stepLen;
  logic [RES_W-1:0] trialBit;

  // ********************************
  // sequencing
  // ********************************
  // slower time settings stretch every bit step
  assign stepLen  = CNT_W'((32'(conv.timeSel) + 32'd1) * STEP_CYCLES - 32'd1);
  assign trialBit = RES_W'(1) << st_q.bitIdx;

  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    case (st_q.state)
      ADCC_IDLE: begin
        if (conv.enable) begin
          st_d.state = ADCC_SAMPLE;
          st_d.cnt   = CNT_W'(SAMPLE_CYCLES - 1);
        end
      end
      ADCC_SAMPLE: begin
        if (st_q.cnt == '0) begin
          st_d.state  = ADCC_CONVERT;
          st_d.cnt    = stepLen;
          st_d.bitIdx = BIT_IDX_W'(RES_W - 1);
          st_d.code   = RES_W'(1) << (RES_W - 1);
        end else begin
          st_d.cnt = st_q.cnt - CNT_W'(1);
        end
      end
      ADCC_CONVERT: begin
        if (st_q.cnt != '0) begin
          st_d.cnt = st_q.cnt - CNT_W'(1);
        end else begin
          if (!conv.compHigh) begin
            st_d.code = st_q.code & ~trialBit;
          end
          if (st_q.bitIdx == '0) begin
            st_d.result = conv.compHigh ? st_q.code : (st_q.code & ~trialBit);
            st_d.done   = 1'b1;
            // next conversion follows with no idle gap
            st_d.state  = ADCC_SAMPLE;
            st_d.cnt    = CNT_W'(SAMPLE_CYCLES - 1);
          end else begin
            st_d.bitIdx = st_q.bitIdx - BIT_IDX_W'(1);
            st_d.code   = st_d.code | (trialBit >> 1);
            st_d.cnt    = stepLen;
          end
        end
      end
      default: st_d.state = ADCC_IDLE;
    endcase
    // abort or run cleared drops the conversion on the spot
    if (conv.abort || !conv.enable) begin
      st_d.state = ADCC_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{state: ADCC_IDLE, cnt: '0, bitIdx: '0, code: '0, result: RES_RESET, done: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign conv.busy     = st_q.state != ADCC_IDLE;
  assign conv.sampling = st_q.state == ADCC_SAMPLE;
  assign conv.done     = st_q.done;
  assign conv.result   = st_q.result;
  assign conv.dacCode  = st_q.code;

  // ********************************
  // checks
  // ********************************
  // the run bit after the write decides the restart, not the one before it
  a_abort_restart: assert property (@(posedge core_clk) disable iff (!rstn)
    conv.abort ##1 (conv.enable && !conv.abort) |-> !conv.busy ##1 conv.busy)
    else $error("abort did not restart conversion");
  a_next_at_once: assert property (@(posedge core_clk) disable iff (!rstn)
    st_d.done && conv.enable && !conv.abort |=> conv.done && conv.sampling)
    else $error("next conversion did not follow completion");
endmodule

// [tb/adcc_testbench.sv]
// self-checking bench for the converter control block
// assumes adcc_pkg and adcc_ctrl; an ideal comparator is modelled here
`timescale 1ns/1ns
module testbench
  import adcc_pkg::*;
;
  // ****************
  // stimulus and model state
  // ****************
  logic              core_clk = 1'b0;
  logic              rstn     = 1'b0;
  logic [ADDR_W-1:0] regAddr  = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic              regWr    = 1'b0;
  logic              regRd    = 1'b0;
  logic [DATA_W-1:0] regRdata;
  logic [CHAN_W-1:0] chanSel;
  logic              compPower;
  logic              sampleHold;
  logic [RES_W-1:0]  dacCode;
  logic              compHigh;
  logic              convDoneIrq;
  logic              irqOut;
  logic [RES_W-1:0]  ainQ [4];
  logic [DATA_W-1:0] rdVal;
  logic              irqAtRd;
  logic [RES_W-1:0]  oldRes;
  int                miscompares = 0;
  int                nCompared   = 0;
  int                seed        = 50933;
  int                period;
  int                n;

  // ideal comparator: the result must equal the selected input exactly
  // pins stay analog throughout: no port or alternate-function traffic
  assign compHigh = ainQ[chanSel] >= dacCode;
  always #4 core_clk = ~core_clk;

  adcc_ctrl #(.SAMPLE_CYCLES(2), .STEP_CYCLES(1)) dut (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .regAddr     (regAddr),
    .regWdata    (regWdata),
    .regWr       (regWr),
    .regRd       (regRd),
    .regRdata    (regRdata),
    .chanSel     (chanSel),
    .compPower   (compPower),
    .sampleHold  (sampleHold),
    .dacCode     (dacCode),
    .compHigh    (compHigh),
    .convDoneIrq (convDoneIrq),
    .irqOut      (irqOut)
  );

  // ****************
  // bus tasks; every task starts and ends 1 ns after a rising edge
  // ****************
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    nCompared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // strobe dropped with a gap so no signal is assigned twice in a step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    tick();
    regWr <= 1'b0;
    tick();
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    regAddr <= a;
    regRd   <= 1'b1;
    tick();
    regRd   <= 1'b0;
    rdVal   = regRdata;
    irqAtRd = convDoneIrq;
    tick();
  endtask

  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    rd(a);
    chk(rdVal, exp);
  endtask

  task automatic waitIrq(output int cnt);
    cnt = 0;
    // bus stays quiet while converting, as a halted cpu would
    do begin
      tick();
      cnt++;
    end while (convDoneIrq !== 1'b1 && cnt < 500);
    chk({15'h0, convDoneIrq}, 16'h0001);
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    wrap_up();
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    for (int i = 0; i < 4; i++) begin
      ainQ[i] = 10'($random(seed));
    end
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    tick();
    for (int a = 0; a < 8; a++) begin
      rdChk(3'(a), 16'h0000);
    end
    chk({13'h0, chanSel, compPower}, 16'h0000);
    // reserved mode bits written as ones must read back as zero
    wr(OFS_MODE, 16'h0047);
    rdChk(OFS_MODE, 16'h0001);
    chk({15'h0, compPower}, 16'h0001);
    // power bit settles just over 1 us before the first run
    for (int i = 0; i < 130; i++) begin
      tick();
      chk({14'h0, sampleHold, convDoneIrq}, 16'h0000);
    end
    wr(OFS_MASK, 16'h0001);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CHAN, 16'(c));
      chk({14'h0, chanSel}, 16'(c));
      wr(OFS_STAT, 16'h0001);
      wr(OFS_MODE, 16'h0081);
      waitIrq(n);
      chk({15'h0, sampleHold}, 16'h0001);
      tick();
      chk({15'h0, convDoneIrq}, 16'h0000);
      rdChk(OFS_RESULT, 16'(ainQ[c]));
      rdChk(OFS_RESHI, 16'(ainQ[c] >> 2));
      rdChk(OFS_STAT, 16'h0001);
      chk({15'h0, irqOut}, 16'h0001);
      wr(OFS_MODE, 16'h0001);
    end
    wr(OFS_MASK, 16'h0000);
    chk({15'h0, irqOut}, 16'h0000);
    wr(OFS_MASK, 16'h0001);
    chk({15'h0, irqOut}, 16'h0001);
    wr(OFS_STAT, 16'h0001);
    chk({15'h0, irqOut}, 16'h0000);
    // stop in mid conversion: nothing may complete afterwards
    wr(OFS_MODE, 16'h0081);
    repeat (4) tick();
    wr(OFS_MODE, 16'h0001);
    for (int i = 0; i < 60; i++) begin
      tick();
      chk({14'h0, sampleHold, convDoneIrq}, 16'h0000);
    end
    rdChk(OFS_STAT, 16'h0000);
    // channel change with the flag set, aborting a running conversion
    wr(OFS_CHAN, 16'h0000);
    wr(OFS_MODE, 16'h0081);
    waitIrq(n);
    wr(OFS_CHAN, 16'h0003);
    rdChk(OFS_STAT, 16'h0001);
    waitIrq(n);
    rdChk(OFS_RESULT, 16'(ainQ[3]));
    // result read colliding with the next completion
    waitIrq(n);
    ainQ[3] <= 10'($random(seed));
    waitIrq(period);
    oldRes = ainQ[3];
    ainQ[3] <= 10'($random(seed));
    repeat (period - 1) tick();
    rd(OFS_RESULT);
    chk(rdVal, 16'(oldRes));
    chk({15'h0, irqAtRd}, 16'h0001);
    rdChk(OFS_RESULT, 16'(ainQ[3]));
    // channel write colliding with a completion drops result and flag
    waitIrq(n);
    oldRes = ainQ[3];
    ainQ[3] <= ~ainQ[3];
    wr(OFS_STAT, 16'h0001);
    repeat (period - 3) tick();
    wr(OFS_CHAN, 16'h0000);
    rdChk(OFS_STAT, 16'h0000);
    rdChk(OFS_RESULT, 16'(oldRes));
    waitIrq(n);
    rdChk(OFS_RESULT, 16'(ainQ[0]));
    // ready for stop mode: run and comparator power both off
    wr(OFS_MODE, 16'h0000);
    chk({14'h0, sampleHold, compPower}, 16'h0000);
    wrap_up();
  end
endmodule
